// File: errq_pkg.sv
// Package for the error reporter: error codes, event bit positions, register map.
// Assumes a 32-bit Avalon-MM register bus and a single 125 MHz clock.
package errq_pkg;
  // Error codes, signed 16-bit
  localparam logic signed [15:0] CODE_NONE = 16'sh0000;
  localparam logic signed [15:0] CODE_PROTECTED = -16'sd203;
  localparam logic signed [15:0] CODE_CONFLICT = -16'sd221;
  localparam logic signed [15:0] CODE_HW_FAULT = -16'sd240;
  localparam logic signed [15:0] CODE_HW_MISSING = -16'sd241;
  localparam logic signed [15:0] CODE_PROG_NAME = -16'sd282;
  localparam logic signed [15:0] CODE_PROG_RUNNING = -16'sd284;
  localparam logic signed [15:0] CODE_PROG_SYNTAX = -16'sd285;
  localparam logic signed [15:0] CODE_SYS_CONVERT = -16'sd310;
  localparam logic signed [15:0] CODE_CAL_LOST = -16'sd313;
  localparam logic signed [15:0] CODE_SAVE_LOST = -16'sd314;
  localparam logic signed [15:0] CODE_CONFIG_LOST = -16'sd315;
  localparam logic signed [15:0] CODE_SELFTEST = -16'sd330;
  localparam logic signed [15:0] CODE_OVERFLOW = -16'sd350;
  localparam logic signed [15:0] CODE_COMM = -16'sd360;
  localparam logic signed [15:0] CODE_PARITY = -16'sd361;
  localparam logic signed [15:0] CODE_FRAMING = -16'sd362;
  localparam logic signed [15:0] CODE_OVERRUN = -16'sd363;
  localparam logic signed [15:0] CODE_QUERY = -16'sd400;
  localparam logic signed [15:0] CODE_INTERRUPTED = -16'sd410;
  // Class bounds
  localparam logic signed [15:0] EXEC_LO = -16'sd299;
  localparam logic signed [15:0] EXEC_HI = -16'sd200;
  localparam logic signed [15:0] DEV_LO = -16'sd399;
  localparam logic signed [15:0] DEV_HI = -16'sd300;
  localparam logic signed [15:0] POS_LO = 16'sd1;
  localparam logic signed [15:0] POS_HI = 16'sd32767;
  localparam logic signed [15:0] QRY_LO = -16'sd499;
  localparam logic signed [15:0] QRY_HI = -16'sd400;
  // Event status bit positions
  localparam int ESR_QUERY_BIT = 2;
  localparam int ESR_DEVICE_BIT = 3;
  localparam int ESR_EXEC_BIT = 4;
  localparam int ESR_WIDTH = 8;
  // Number of error sources
  localparam int NSRC = 19;
  // Register byte addresses
  localparam logic [3:0] ADDR_ERR_POP = 4'h0;
  localparam logic [3:0] ADDR_ESR = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // Control bits
  localparam int CTRL_CLS_BIT = 0;
  localparam int CTRL_SELFTEST_BIT = 1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// File: errq_mem.sv
// Small code store for the error queue; read data come from a register.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/10ps
module errq_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic MCLK,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [DEPTH];

  // Registered read; write-through is not needed since reads lag writes
  always_ff @(posedge MCLK)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// File: err_reporter.sv
// Error reporter: turns unit error strobes into signed codes, queues them,
// sets event status class bits, and serves it all over Avalon-MM.
// Assumes error strobes are one-cycle pulses on MCLK from internal units,
// that EVAL_DONE stays high while an execution unit's parameter is final,
// and that the bus master holds each request until waitrequest is low.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module err_reporter #(
  parameter int DEPTH = 16
) (
  input wire logic MCLK,
  input wire logic RSTN,
  // Avalon-MM slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Execution control
  input wire logic EVAL_DONE,
  input wire logic CMD_PROTECTED,
  input wire logic SETTING_CONFLICT,
  input wire logic HW_FAULT,
  input wire logic HW_MISSING,
  // Auto-sequence control
  input wire logic PROG_BAD_NAME,
  input wire logic PROG_RUNNING_OP,
  input wire logic PROG_SYNTAX,
  // Serial receiver
  input wire logic RX_PARITY_ERR,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_OVERRUN,
  input wire logic RX_COMM_ERR,
  // Storage and calibration
  input wire logic SAVE_LOST,
  input wire logic CONFIG_LOST,
  input wire logic CAL_LOST,
  input wire logic CONVERT_FAIL,
  input wire logic SELFTEST_FAIL,
  // Output queue control
  input wire logic QUERY_INTERRUPTED,
  input wire logic QUERY_FAULT,
  // Status to the status-byte logic
  output logic QUEUE_NOT_EMPTY,
  output logic [7:0] EVENT_STATUS
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;
  localparam int ESR_W = errq_pkg::ESR_WIDTH;

  // Elaboration check: queue store is addressed by a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  // Elaboration check: the source and code tables below fill indices 0 to 18
  if (errq_pkg::NSRC != 19)
  begin : g_bad_nsrc
    $error("NSRC must match the written source table");
  end

  // Elaboration check: class flags fill one byte of port and read word
  if (ESR_W != 8)
  begin : g_bad_esr
    $error("ESR_WIDTH must be 8");
  end

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [ESR_W-1:0] esr;
    logic [31:0] rdata;
    logic waitreq;
    logic rd_pend;
    logic empty_rd;
    logic not_empty;
    logic selftest_mode;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;

  logic [errq_pkg::NSRC-1:0] src;
  logic [15:0] codes [errq_pkg::NSRC];
  logic [15:0] mem_rd;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  // Class decode of the posted code into the event status bits
  function automatic logic [ESR_W-1:0] class_bits(input logic signed [15:0] c);
    logic [ESR_W-1:0] b;
    b = '0;
    if (c >= errq_pkg::EXEC_LO && c <= errq_pkg::EXEC_HI)
    begin
      b[errq_pkg::ESR_EXEC_BIT] = 1'b1;
    end
    if ((c >= errq_pkg::DEV_LO && c <= errq_pkg::DEV_HI) ||
        (c >= errq_pkg::POS_LO && c <= errq_pkg::POS_HI))
    begin
      b[errq_pkg::ESR_DEVICE_BIT] = 1'b1;
    end
    if (c >= errq_pkg::QRY_LO && c <= errq_pkg::QRY_HI)
    begin
      b[errq_pkg::ESR_QUERY_BIT] = 1'b1;
    end
    return b;
  endfunction

  // Source vector in priority order, index 0 highest
  always_comb
  begin
    // Execution errors wait for evaluation to finish
    src[0] = CMD_PROTECTED & EVAL_DONE;
    src[1] = SETTING_CONFLICT & EVAL_DONE;
    src[2] = HW_FAULT & EVAL_DONE;
    src[3] = HW_MISSING & EVAL_DONE;
    src[4] = PROG_BAD_NAME;
    src[5] = PROG_RUNNING_OP;
    src[6] = PROG_SYNTAX;
    src[7] = RX_PARITY_ERR;
    src[8] = RX_FRAMING_ERR;
    src[9] = RX_OVERRUN;
    // Generic comm fault only when no specific one applies
    src[10] = RX_COMM_ERR & ~(RX_PARITY_ERR | RX_FRAMING_ERR | RX_OVERRUN);
    src[11] = SAVE_LOST;
    src[12] = CONFIG_LOST;
    src[13] = CAL_LOST;
    src[14] = CONVERT_FAIL;
    src[15] = SELFTEST_FAIL;
    src[16] = QUERY_INTERRUPTED;
    src[17] = QUERY_FAULT & ~QUERY_INTERRUPTED;
    src[18] = 1'b0;
  end

  // Code table matching the source vector
  // Slot 18 is spare: its source is tied off and its code is never queued
  assign codes[0] = errq_pkg::CODE_PROTECTED;
  assign codes[1] = errq_pkg::CODE_CONFLICT;
  assign codes[2] = errq_pkg::CODE_HW_FAULT;
  assign codes[3] = errq_pkg::CODE_HW_MISSING;
  assign codes[4] = errq_pkg::CODE_PROG_NAME;
  assign codes[5] = errq_pkg::CODE_PROG_RUNNING;
  assign codes[6] = errq_pkg::CODE_PROG_SYNTAX;
  assign codes[7] = errq_pkg::CODE_PARITY;
  assign codes[8] = errq_pkg::CODE_FRAMING;
  assign codes[9] = errq_pkg::CODE_OVERRUN;
  assign codes[10] = errq_pkg::CODE_COMM;
  assign codes[11] = errq_pkg::CODE_SAVE_LOST;
  assign codes[12] = errq_pkg::CODE_CONFIG_LOST;
  assign codes[13] = errq_pkg::CODE_CAL_LOST;
  assign codes[14] = errq_pkg::CODE_SYS_CONVERT;
  assign codes[15] = errq_pkg::CODE_SELFTEST;
  assign codes[16] = errq_pkg::CODE_INTERRUPTED;
  assign codes[17] = errq_pkg::CODE_QUERY;
  assign codes[18] = errq_pkg::CODE_NONE;

  // Queue store with registered read port
  // Store is not reset; pointers and count alone decide what is valid
  errq_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .MCLK(MCLK),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(cur_ff.rd_ptr),
    .rd_data(mem_rd)
  );

  // Next-state logic: bus, pops, pushes, class bits
  always_comb
  begin
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic pop;
    logic cls;
    logic [AW-1:0] last;
    nxt_ff = cur_ff;
    wp = cur_ff.wr_ptr;
    rp = cur_ff.rd_ptr;
    cnt = cur_ff.count;
    pop = 1'b0;
    cls = 1'b0;
    mem_we = 1'b0;
    mem_wa = wp;
    mem_wd = errq_pkg::CODE_NONE;
    // Newest entry sits one below the write pointer, wrapping through zero
    last = wp - AW'(1);
    nxt_ff.waitreq = 1'b1;
    // Read of the queue needs one extra cycle for the store's register
    if (READ && cur_ff.waitreq && !cur_ff.rd_pend)
    begin
      nxt_ff.rd_pend = 1'b1;
      // Emptiness frozen now, so an entry pushed meanwhile waits for the next read
      nxt_ff.empty_rd = (cur_ff.count == '0);
    end
    else if (cur_ff.rd_pend)
    begin
      nxt_ff.rd_pend = 1'b0;
      nxt_ff.waitreq = 1'b0;
      // The master still holds the address, so it selects the answer here
      unique case (ADDRESS)
        errq_pkg::ADDR_ERR_POP:
        begin
          if (cur_ff.empty_rd)
          begin
            nxt_ff.rdata = 32'h00000000;
          end
          else
          begin
            nxt_ff.rdata = {{16{mem_rd[15]}}, mem_rd};
            pop = 1'b1;
          end
        end
        errq_pkg::ADDR_ESR:
        begin
          nxt_ff.rdata = {24'h000000, cur_ff.esr};
          // Reading the event status clears it, like the standard query
          nxt_ff.esr = '0;
        end
        errq_pkg::ADDR_CTRL:
          nxt_ff.rdata = {30'h0, cur_ff.selftest_mode, 1'b0};
        errq_pkg::ADDR_STATUS:
          nxt_ff.rdata = {{(32-CW-1){1'b0}}, cur_ff.count, cur_ff.not_empty};
        default:
          nxt_ff.rdata = errq_pkg::UNMAPPED_DATA;
      endcase
    end
    else if (WRITE && cur_ff.waitreq)
    begin
      // Waitrequest is registered, so the write is only accepted next edge
      nxt_ff.waitreq = 1'b0;
    end
    else if (WRITE)
    begin
      // Acting here keeps the effect on the edge the master completes on
      if (ADDRESS == errq_pkg::ADDR_CTRL && BYTEENABLE[0])
      begin
        cls = WRITEDATA[errq_pkg::CTRL_CLS_BIT];
        nxt_ff.selftest_mode = WRITEDATA[errq_pkg::CTRL_SELFTEST_BIT];
      end
    end
    // Pop; reading the final entry leaves the queue empty
    if (pop)
    begin
      rp = rp + AW'(1);
      cnt = cnt - CW'(1);
    end
    // Clear-status empties queue and event status
    // It runs before the push below, so an error of the same cycle survives
    if (cls)
    begin
      rp = '0;
      wp = '0;
      cnt = '0;
      nxt_ff.esr = '0;
    end
    // Push highest-priority error of this cycle
    // One code per cycle; lower-priority errors of the same cycle are lost
    for (int i = errq_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (src[i])
      begin
        mem_wd = codes[i];
      end
    end
    if (|src)
    begin
      if (cnt == CW'(DEPTH))
      begin
        // Full: newest entry replaced, cause dropped
        mem_we = 1'b1;
        mem_wa = last;
        mem_wd = errq_pkg::CODE_OVERFLOW;
      end
      else
      begin
        mem_we = 1'b1;
        mem_wa = wp;
        wp = wp + AW'(1);
        cnt = cnt + CW'(1);
      end
      // Class bit set wins over a same-cycle clear
      nxt_ff.esr = nxt_ff.esr | class_bits(mem_wd);
    end
    nxt_ff.wr_ptr = wp;
    nxt_ff.rd_ptr = rp;
    nxt_ff.count = cnt;
    nxt_ff.not_empty = (cnt != '0);
  end

  // State register, synchronous reset
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      cur_ff <= '{waitreq: 1'b1, default: '0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign READDATA = cur_ff.rdata;
  assign WAITREQUEST = cur_ff.waitreq;
  assign QUEUE_NOT_EMPTY = cur_ff.not_empty;
  assign EVENT_STATUS = cur_ff.esr;
endmodule

// File: err_reporter_asserts.sv
// Checker for the error reporter: bus handshake, class bits, queue flag.
// Assumes one clock, MCLK, and the synchronous active-low reset RSTN.
`timescale 1ns/10ps
module err_reporter_chk (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] ADDRESS,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic EVAL_DONE,
  input wire logic CMD_PROTECTED,
  input wire logic RX_PARITY_ERR,
  input wire logic QUERY_FAULT,
  input wire logic QUEUE_NOT_EMPTY,
  input wire logic [7:0] EVENT_STATUS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Answer steps: a read spends one cycle pending first
  sequence rd_ack;
    WAITREQUEST ##1 !WAITREQUEST;
  endsequence
  sequence wr_ack;
    !WAITREQUEST;
  endsequence
  chk_read_latency: assert property ($rose(READ) |=> rd_ack)
    else $error("read answer not on time");
  chk_write_latency: assert property ($rose(WRITE) |=> wr_ack)
    else $error("write answer not on time");
  chk_ack_single: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("answer longer than one cycle");
  chk_idle_wait: assert property (!READ && !WRITE |=> WAITREQUEST)
    else $error("answer without a request");
  chk_exec_bit: assert property (EVAL_DONE && CMD_PROTECTED |-> ##[1:4] EVENT_STATUS[4])
    else $error("execution class bit missing");
  chk_device_bit: assert property (RX_PARITY_ERR |-> ##[1:4] EVENT_STATUS[3])
    else $error("device class bit missing");
  chk_query_bit: assert property (QUERY_FAULT |-> ##[1:4] EVENT_STATUS[2])
    else $error("query class bit missing");
  chk_queue_fills: assert property (EVAL_DONE && CMD_PROTECTED |-> ##[1:4] QUEUE_NOT_EMPTY)
    else $error("queue flag not raised");
  chk_code_signext: assert property (READ && !WAITREQUEST && ADDRESS == 4'h0
    |-> READDATA[31:16] == {16{READDATA[15]}})
    else $error("code not sign extended");
endmodule
bind err_reporter err_reporter_chk err_reporter_chk_inst (.MCLK(MCLK), .RSTN(RSTN),
  .READ(READ), .WRITE(WRITE), .ADDRESS(ADDRESS), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .EVAL_DONE(EVAL_DONE), .CMD_PROTECTED(CMD_PROTECTED),
  .RX_PARITY_ERR(RX_PARITY_ERR), .QUERY_FAULT(QUERY_FAULT),
  .QUEUE_NOT_EMPTY(QUEUE_NOT_EMPTY), .EVENT_STATUS(EVENT_STATUS));

// File: host_link.sv
// Remote host model: masters the register bus to read and clear errors.
// Assumes the slave answers by dropping waitrequest for one cycle.
`timescale 1ns/10ps
module host_link (
  input wire logic MCLK,
  input wire logic WAITREQUEST,
  input wire logic [31:0] READDATA,
  output logic [3:0] ADDRESS,
  output logic READ,
  output logic WRITE,
  output logic [31:0] WRITEDATA,
  output logic [3:0] BYTEENABLE
);
  // Idle bus from time zero
  initial
  begin
    ADDRESS = 4'h0;
    READ = 1'b0;
    WRITE = 1'b0;
    WRITEDATA = 32'h0;
    BYTEENABLE = 4'hf;
  end
  // One transfer held until waitrequest is seen low; no fixed latency assumed
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge MCLK);
    ADDRESS <= a;
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= d;
    do @(posedge MCLK); while (WAITREQUEST !== 1'b0);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    // Released lines show a changed value, not the stale one
    WRITEDATA <= ~d;
    ADDRESS <= ~a;
  endtask
endmodule

// File: tb_err_reporter.sv
// Testbench for the error reporter: pulses error sources, reads codes back.
// Assumes host_link masters the bus and a queue depth of 4.
`timescale 1ns/10ps
module tb_err_reporter;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic EVAL_DONE = 1'b0;
  logic [17:0] errs = '0;
  logic [3:0] ADDRESS;
  logic READ;
  logic WRITE;
  logic [31:0] WRITEDATA;
  logic [31:0] READDATA;
  logic [3:0] BYTEENABLE;
  logic WAITREQUEST;
  logic QUEUE_NOT_EMPTY;
  logic [7:0] EVENT_STATUS;
  logic [31:0] q;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Codes in source priority order
  int code_tab[18] = '{-203, -221, -240, -241, -282, -284, -285, -361, -362, -363,
    -360, -314, -315, -313, -310, -330, -410, -400};

  err_reporter #(.DEPTH(4)) err_reporter_inst (.MCLK(MCLK), .RSTN(RSTN),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .EVAL_DONE(EVAL_DONE), .CMD_PROTECTED(errs[0]), .SETTING_CONFLICT(errs[1]),
    .HW_FAULT(errs[2]), .HW_MISSING(errs[3]), .PROG_BAD_NAME(errs[4]),
    .PROG_RUNNING_OP(errs[5]), .PROG_SYNTAX(errs[6]), .RX_PARITY_ERR(errs[7]),
    .RX_FRAMING_ERR(errs[8]), .RX_OVERRUN(errs[9]), .RX_COMM_ERR(errs[10]),
    .SAVE_LOST(errs[11]), .CONFIG_LOST(errs[12]), .CAL_LOST(errs[13]),
    .CONVERT_FAIL(errs[14]), .SELFTEST_FAIL(errs[15]), .QUERY_INTERRUPTED(errs[16]),
    .QUERY_FAULT(errs[17]), .QUEUE_NOT_EMPTY(QUEUE_NOT_EMPTY),
    .EVENT_STATUS(EVENT_STATUS));
  host_link host_inst (.MCLK(MCLK), .WAITREQUEST(WAITREQUEST), .READDATA(READDATA),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE));

  // 125 MHz clock
  initial
    forever #4 MCLK = ~MCLK;
  // Hang guard, far above the expected run of about 350 cycles
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      $display("BAD %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    host_inst.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // One-cycle pulse on a set of sources, then let the queue settle
  task automatic pulse(input logic [17:0] m, input logic ev);
    errs <= m;
    EVAL_DONE <= ev;
    @(posedge MCLK);
    errs <= '0;
    repeat (4) @(posedge MCLK);
  endtask
  // Class bit expected from the code range
  function automatic logic [31:0] esr_of(input int c);
    if (c >= -299 && c <= -200)
      return 32'h10;
    if (c >= -499 && c <= -400)
      return 32'h04;
    return 32'h08;
  endfunction

  task automatic t_reset();
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h1, 32'h0);
    $display("test reset done");
  endtask
  // Every source alone: its code, then its class bit (read clears it)
  task automatic t_codes();
    for (int i = 0; i < 18; i++)
    begin
      pulse(18'h00001 << i, 1'b1);
      chk({24'h0, EVENT_STATUS}, esr_of(code_tab[i]));
      rd(4'h0, 32'(code_tab[i]));
      rd(4'h4, esr_of(code_tab[i]));
    end
    $display("test codes done");
  endtask
  // Execution error before evaluation is done must not be posted
  task automatic t_eval();
    pulse(18'h00001, 1'b0);
    chk({24'h0, EVENT_STATUS}, 32'h0);
    rd(4'h0, 32'h0);
    $display("test eval done");
  endtask
  // Same-cycle errors: the higher priority one wins
  task automatic t_prio();
    pulse(18'h10001, 1'b1);
    rd(4'h0, 32'hffffff35);
    rd(4'h0, 32'h0);
    $display("test priority done");
  endtask
  // Clear-status empties the queue; so does reading the last entry
  task automatic t_clear();
    pulse(18'h00002, 1'b1);
    pulse(18'h00080, 1'b1);
    chk({31'h0, QUEUE_NOT_EMPTY}, 32'h1);
    chk({24'h0, EVENT_STATUS}, 32'h18);
    rd(4'hc, 32'h5);
    // Clear-status and the self-test flag in one control write
    host_inst.xfer(1'b1, 4'h8, 32'h3, q);
    rd(4'h8, 32'h2);
    rd(4'h0, 32'h0);
    chk({24'h0, EVENT_STATUS}, 32'h0);
    pulse(18'h00001, 1'b1);
    rd(4'h0, 32'hffffff35);
    @(posedge MCLK);
    chk({31'h0, QUEUE_NOT_EMPTY}, 32'h0);
    $display("test clear done");
  endtask
  // Five errors into four entries: newest becomes overflow, order kept
  task automatic t_overflow();
    int src[5] = '{2, 3, 4, 5, 9};
    int exp[6] = '{-240, -241, -282, -350, 0, 0};
    foreach (src[i])
      pulse(18'h00001 << src[i], 1'b1);
    foreach (exp[i])
      rd(4'h0, 32'(exp[i]));
    $display("test overflow done");
  endtask

  initial
  begin
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    t_reset();
    t_codes();
    t_eval();
    t_prio();
    t_clear();
    t_overflow();
    tally_and_finish();
  end
endmodule
